// File: verilog/info_mon_pkg.sv
// Purpose: Shared constants for the information-code supervisor
// Assumes: 25 MHz system clock, synchronous active-high reset
// Notes:   Field positions of the fault status word and log geometry
package info_mon_pkg;
	localparam int          INFO_W        = 12;
	localparam int          LOG_DEPTH     = 50;
	localparam int          LOG_IDX_W     = 6;
	localparam int          DATE_W        = 16;
	localparam int          TOD_W         = 17;
	localparam int          CNT_W         = 32;
	localparam int          EVT_W         = 16;
	localparam int          TEMP_W        = 16;
	localparam int          FLOW_W        = 20;
	localparam int          PWR_W         = 20;
	localparam int          BIT_SUPPLY    = 0;
	localparam int          BIT_BATT      = 1;
	localparam int          BIT_T1_HI     = 3;
	localparam int          BIT_T2_HI     = 4;
	localparam int          BIT_T1_LO     = 5;
	localparam int          BIT_T2_LO     = 6;
	localparam int          BIT_DT_BAD    = 7;
	localparam int          BIT_AIR       = 8;
	localparam int          BIT_REVERSE   = 9;
	localparam int          BIT_HIGH_FLOW = 11;
	// Bit 10 is never driven
	localparam logic [11:0] INFO_USED_MASK = 12'hbfb;
	localparam logic [15:0] TEMP_MIN_VAL   = 16'h0000;
	// 185,00 degC in hundredths
	localparam logic [15:0] TEMP_MAX_VAL   = 16'h4844;
	localparam logic [19:0] ZERO_FLOW      = 20'h00000;
	localparam logic [19:0] ZERO_POWER     = 20'h00000;
	// Reverse flow persistence, minutes, and the system clock rate
	localparam int          REV_MINUTES    = 10;
	localparam int          CLK_HZ         = 25000000;
	localparam longint      REV_CYCLES     =
		longint'(REV_MINUTES) * 60 * CLK_HZ;
	localparam logic [5:0]  LOG_PTR_RST    = 6'h00;
	localparam logic [15:0] EVT_CNT_RST    = 16'h0000;
	localparam logic [11:0] INFO_RST       = 12'h000;
	// Blink half period of the attention indicator, 0.5 s
	localparam int          BLINK_MS       = 500;
	localparam int          BLINK_CYCLES   = BLINK_MS * (CLK_HZ / 1000);
endpackage : info_mon_pkg

// File: verilog/info_log_if.sv
// Purpose: Carrier between supervisor and its history store
// Assumes: Single clock domain
// Notes:   Write strobe plus indexed read port
`timescale 1ns/10ps
interface info_log_if;
	import info_mon_pkg::*;
	logic                 wr_en;
	logic [DATE_W-1:0]    wr_date;
	logic [TOD_W-1:0]     wr_tod;
	logic [INFO_W-1:0]    wr_info;
	logic [CNT_W-1:0]     wr_heat;
	logic [CNT_W-1:0]     wr_cool;
	logic [CNT_W-1:0]     wr_vol;
	logic [LOG_IDX_W-1:0] rd_idx;
	logic [DATE_W-1:0]    rd_date;
	logic [TOD_W-1:0]     rd_tod;
	logic [INFO_W-1:0]    rd_info;
	logic [CNT_W-1:0]     rd_heat;
	logic [CNT_W-1:0]     rd_cool;
	logic [CNT_W-1:0]     rd_vol;
	logic [LOG_IDX_W-1:0] newest;
	modport ctrl (output wr_en, wr_date, wr_tod, wr_info, wr_heat,
		wr_cool, wr_vol, rd_idx,
		input rd_date, rd_tod, rd_info, rd_heat, rd_cool, rd_vol, newest);
	modport store (input wr_en, wr_date, wr_tod, wr_info, wr_heat,
		wr_cool, wr_vol, rd_idx,
		output rd_date, rd_tod, rd_info, rd_heat, rd_cool, rd_vol, newest);
endinterface : info_log_if

// File: verilog/info_history.sv
// Purpose: Circular store of the latest info-word changes
// Assumes: One write per cycle at most
// Notes:   Read index 0 is the newest entry, 49 the oldest
`timescale 1ns/10ps
module info_history
	import info_mon_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_sys_rst,
	info_log_if.store lg
);
	logic [DATE_W-1:0]    date_mem [LOG_DEPTH];
	logic [TOD_W-1:0]     tod_mem  [LOG_DEPTH];
	logic [INFO_W-1:0]    info_mem [LOG_DEPTH];
	logic [CNT_W-1:0]     heat_mem [LOG_DEPTH];
	logic [CNT_W-1:0]     cool_mem [LOG_DEPTH];
	logic [CNT_W-1:0]     vol_mem  [LOG_DEPTH];
	logic [LOG_IDX_W-1:0] wptr_reg;
	logic [LOG_IDX_W-1:0] wptr_next;
	logic [LOG_IDX_W-1:0] last_reg;
	logic [LOG_IDX_W-1:0] last_next;
	logic [LOG_IDX_W-1:0] rd_slot;

	always_comb begin
		wptr_next = wptr_reg;
		last_next = last_reg;
		if (lg.wr_en) begin
			last_next = wptr_reg;
			wptr_next = (wptr_reg == LOG_IDX_W'(LOG_DEPTH - 1)) ?
				LOG_PTR_RST : wptr_reg + 6'h01;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wptr_reg <= LOG_PTR_RST;
			last_reg <= LOG_PTR_RST;
		end else begin
			wptr_reg <= wptr_next;
			last_reg <= last_next;
		end
	end

	// Entries are rewritten only when the pointer wraps, never by a reconfiguration
	always_ff @(posedge i_clk_sys) begin
		if (lg.wr_en) begin
			date_mem[wptr_reg] <= lg.wr_date;
			tod_mem[wptr_reg]  <= lg.wr_tod;
			info_mem[wptr_reg] <= lg.wr_info;
			heat_mem[wptr_reg] <= lg.wr_heat;
			cool_mem[wptr_reg] <= lg.wr_cool;
			vol_mem[wptr_reg]  <= lg.wr_vol;
		end
	end

	always_comb begin
		if (lg.rd_idx > last_reg)
			rd_slot = LOG_IDX_W'(LOG_DEPTH) + last_reg - lg.rd_idx;
		else
			rd_slot = last_reg - lg.rd_idx;
		if (rd_slot >= LOG_IDX_W'(LOG_DEPTH))
			rd_slot = LOG_PTR_RST;
	end

	assign lg.rd_date = date_mem[rd_slot];
	assign lg.rd_tod  = tod_mem[rd_slot];
	assign lg.rd_info = info_mem[rd_slot];
	assign lg.rd_heat = heat_mem[rd_slot];
	assign lg.rd_cool = cool_mem[rd_slot];
	assign lg.rd_vol  = vol_mem[rd_slot];
	assign lg.newest  = last_reg;

	ptr_wrap_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		lg.wr_en && wptr_reg == 6'h31 |=> wptr_reg == 6'h00)
		else $error("history pointer did not wrap at 50");
endmodule : info_history

// File: verilog/info_code_monitor.sv
// Purpose: Fault status word, attention flag, change log, transport state
// Assumes: Fault inputs on this clock, i_eval a one-cycle strobe
// Notes:   Readout substitution and energy gating leave through flops
`timescale 1ns/10ps

module info_code_monitor
	import info_mon_pkg::*;
#(
	parameter longint REV_HOLD_CYCLES = REV_CYCLES
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_eval,
	input  wire logic                 i_supply_lost,
	input  wire logic                 i_low_battery,
	input  wire logic                 i_inlet_open,
	input  wire logic                 i_outlet_open,
	input  wire logic                 i_inlet_short,
	input  wire logic                 i_outlet_short,
	input  wire logic                 i_dt_invalid,
	input  wire logic                 i_flow_air,
	input  wire logic                 i_flow_reverse_1pct,
	input  wire logic                 i_flow_over_max_1h,
	input  wire logic [INFO_W-1:0]    i_bit_enable,
	input  wire logic                 i_info_selected,
	input  wire logic                 i_integration,
	input  wire logic                 i_finish_configuration_command,
	input  wire logic                 i_menu_radio_on,
	input  wire logic                 i_technician_menu,
	input  wire logic                 i_test_menu_enter,
	input  wire logic                 i_test_menu_exit,
	input  wire logic [TEMP_W-1:0]    i_inlet_temperature,
	input  wire logic [TEMP_W-1:0]    i_outlet_temperature,
	input  wire logic [FLOW_W-1:0]    i_flow_volume_channel,
	input  wire logic [PWR_W-1:0]     i_power,
	input  wire logic [DATE_W-1:0]    i_date,
	input  wire logic [TOD_W-1:0]     i_time_of_day,
	input  wire logic [CNT_W-1:0]     i_heat_energy_count,
	input  wire logic [CNT_W-1:0]     i_cooling_energy_count,
	input  wire logic [CNT_W-1:0]     i_volume_count,
	input  wire logic [LOG_IDX_W-1:0] i_log_rd_idx,
	output logic [INFO_W-1:0]         o_meter_fault_status_word,
	output logic                      o_attention_on,
	output logic [EVT_W-1:0]          o_event_count,
	output logic                      o_transport,
	output logic                      o_power_save_seq,
	output logic                      o_setup_open,
	output logic                      o_radio_on,
	output logic                      o_heat_accum_en,
	output logic                      o_cool_accum_en,
	output logic                      o_temp_dashes,
	output logic                      o_flow_dashes,
	output logic [TEMP_W-1:0]         o_ser_inlet_temperature,
	output logic [TEMP_W-1:0]         o_ser_outlet_temperature,
	output logic [FLOW_W-1:0]         o_ser_flow,
	output logic [PWR_W-1:0]          o_ser_power,
	output logic [DATE_W-1:0]         o_log_date,
	output logic [TOD_W-1:0]          o_log_tod,
	output logic [INFO_W-1:0]         o_log_info,
	output logic [CNT_W-1:0]          o_log_heat,
	output logic [CNT_W-1:0]          o_log_cool,
	output logic [CNT_W-1:0]          o_log_vol
);
	default clocking sys_cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	info_log_if lg ();
	info_history u_hist (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.lg        (lg.store)
	);
	function automatic logic t_fail(input logic [INFO_W-1:0] w);
		return |w[BIT_T2_LO:BIT_T1_HI];
	endfunction : t_fail
	function automatic logic f_fail(input logic [INFO_W-1:0] w);
		return w[BIT_AIR] | w[BIT_REVERSE];
	endfunction : f_fail

	// Reverse persistence; ten minutes of cycles need 34 bits
	logic [33:0] rev_cnt_reg, rev_cnt_next;
	logic        rev_reg, rev_next;
	always_comb begin
		rev_cnt_next = rev_cnt_reg;
		rev_next     = rev_reg;
		if (i_eval) begin
			if (!i_flow_reverse_1pct) begin
				rev_next     = 1'b0;
			end else if (rev_cnt_reg >= 34'(REV_HOLD_CYCLES - 1)) begin
				rev_next = 1'b1;
			end
		end
		// A gap in reverse flow restarts the hold time
		if (!i_flow_reverse_1pct)
			rev_cnt_next = '0;
		else if (!rev_next)
			rev_cnt_next = rev_cnt_reg + 34'h1;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rev_cnt_reg <= '0;
			rev_reg     <= 1'b0;
		end else begin
			rev_cnt_reg <= rev_cnt_next;
			rev_reg     <= rev_next;
		end
	end

	// Word assembly; bit 2 and bit 10 never set
	logic [INFO_W-1:0] word_new;
	always_comb begin
		word_new                = '0;
		word_new[BIT_SUPPLY]    = i_supply_lost;
		word_new[BIT_BATT]      = i_low_battery;
		word_new[BIT_T1_HI]     = i_inlet_open;
		word_new[BIT_T2_HI]     = i_outlet_open;
		word_new[BIT_T1_LO]     = i_inlet_short;
		word_new[BIT_T2_LO]     = i_outlet_short;
		word_new[BIT_DT_BAD]    = i_dt_invalid;
		word_new[BIT_AIR]       = i_flow_air;
		word_new[BIT_REVERSE]   = rev_next;
		// Over nominal flow comes from i_flow_over_max_1h on bit 11
		word_new[BIT_HIGH_FLOW] = i_flow_over_max_1h;
		word_new = word_new & INFO_USED_MASK;
	end

	// Status word, event counter, transport and radio
	logic [INFO_W-1:0] word_reg, word_next;
	logic [EVT_W-1:0]  evt_reg, evt_next;
	logic              trans_reg, trans_next;
	logic              setup_reg, setup_next;
	logic              radio_reg, radio_next;
	logic              test_reg, test_next;
	logic              event_hit;

	always_comb begin
		word_next  = word_reg;
		evt_next   = evt_reg;
		trans_next = trans_reg;
		setup_next = setup_reg;
		radio_next = radio_reg;
		test_next  = test_reg;
		event_hit  = 1'b0;
		if (i_eval) begin
			word_next = word_new;
			// Only enabled bits count
			event_hit = |((word_new ^ word_reg) & i_bit_enable) &&
				!trans_reg;
		end
		if (event_hit)
			evt_next = evt_reg + 16'h1;
		if (i_integration)
			trans_next = 1'b0;
		if (i_finish_configuration_command) begin
			trans_next = 1'b0;
			setup_next = 1'b0;
		end
		if (i_test_menu_enter)
			test_next = 1'b1;
		else if (i_test_menu_exit)
			test_next = 1'b0;
		// Menu enable leaves trans_next alone
		if (i_menu_radio_on && !test_next)
			radio_next = 1'b1;
		if (i_integration && !test_next)
			radio_next = 1'b1;
		if (test_next)
			radio_next = 1'b0;
	end

	// Transport set only by reset
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			word_reg  <= INFO_RST;
			evt_reg   <= EVT_CNT_RST;
			trans_reg <= 1'b1;
			setup_reg <= 1'b1;
			radio_reg <= 1'b0;
			test_reg  <= 1'b0;
		end else begin
			word_reg  <= word_next;
			evt_reg   <= evt_next;
			trans_reg <= trans_next;
			setup_reg <= setup_next;
			radio_reg <= radio_next;
			test_reg  <= test_next;
		end
	end

	assign lg.wr_en   = event_hit;
	assign lg.wr_date = i_date;
	assign lg.wr_tod  = i_time_of_day;
	assign lg.wr_info = word_new;
	assign lg.wr_heat = i_heat_energy_count;
	assign lg.wr_cool = i_cooling_energy_count;
	assign lg.wr_vol  = i_volume_count;
	assign lg.rd_idx  = i_log_rd_idx;

	// Blink timer for the attention indicator
	logic [24:0] blink_cnt_reg, blink_cnt_next;
	logic        blink_reg, blink_next;
	always_comb begin
		blink_cnt_next = blink_cnt_reg + 25'h1;
		blink_next     = blink_reg;
		if (blink_cnt_reg >= 25'(BLINK_CYCLES - 1)) begin
			blink_cnt_next = '0;
			blink_next     = !blink_reg;
		end
	end

	// Registered outputs
	logic             attn_next;
	logic [TEMP_W-1:0] t1_out, t2_out;
	logic [FLOW_W-1:0] flow_out;
	logic [PWR_W-1:0]  pwr_out;
	always_comb begin
		attn_next = 1'b0;
		if (word_reg != '0)
			attn_next = i_info_selected ? 1'b1 : blink_reg;
		t1_out = i_inlet_temperature;
		t2_out = i_outlet_temperature;
		if (word_reg[BIT_T1_LO]) t1_out = TEMP_MIN_VAL;
		if (word_reg[BIT_T1_HI]) t1_out = TEMP_MAX_VAL;
		if (word_reg[BIT_T2_LO]) t2_out = TEMP_MIN_VAL;
		if (word_reg[BIT_T2_HI]) t2_out = TEMP_MAX_VAL;
		flow_out = f_fail(word_reg) ? ZERO_FLOW : i_flow_volume_channel;
		// Bit 7 is outside t_fail, so no substitution for it
		pwr_out = (t_fail(word_reg) || f_fail(word_reg)) ?
			ZERO_POWER : i_power;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			blink_cnt_reg             <= '0;
			blink_reg                 <= 1'b0;
			o_attention_on            <= 1'b0;
			o_ser_inlet_temperature   <= '0;
			o_ser_outlet_temperature  <= '0;
			o_ser_flow                <= '0;
			o_ser_power               <= '0;
			o_heat_accum_en           <= 1'b0;
			o_cool_accum_en           <= 1'b0;
			o_temp_dashes             <= 1'b0;
			o_flow_dashes             <= 1'b0;
			o_log_date                <= '0;
			o_log_tod                 <= '0;
			o_log_info                <= '0;
			o_log_heat                <= '0;
			o_log_cool                <= '0;
			o_log_vol                 <= '0;
		end else begin
			blink_cnt_reg             <= blink_cnt_next;
			blink_reg                 <= blink_next;
			o_attention_on            <= attn_next;
			o_ser_inlet_temperature   <= t1_out;
			o_ser_outlet_temperature  <= t2_out;
			o_ser_flow                <= flow_out;
			o_ser_power               <= pwr_out;
			// Both energies need both sensors and flow
			o_heat_accum_en <= !(t_fail(word_reg) || f_fail(word_reg));
			o_cool_accum_en <= !(t_fail(word_reg) || f_fail(word_reg));
			o_temp_dashes   <= t_fail(word_reg);
			o_flow_dashes   <= f_fail(word_reg);
			o_log_date                <= lg.rd_date;
			o_log_tod                 <= lg.rd_tod;
			o_log_info                <= lg.rd_info;
			o_log_heat                <= lg.rd_heat;
			o_log_cool                <= lg.rd_cool;
			o_log_vol                 <= lg.rd_vol;
		end
	end

	assign o_meter_fault_status_word = word_reg;
	assign o_event_count             = evt_reg;
	assign o_transport               = trans_reg;
	assign o_power_save_seq          = trans_reg;
	assign o_setup_open              = setup_reg;
	assign o_radio_on                = radio_reg;
	sequence s_change;
		i_eval && !trans_reg && |((word_new ^ word_reg) & i_bit_enable);
	endsequence
	evt_count_a: assert property (s_change |=>
		evt_reg == $past(evt_reg) + 16'h1)
		else $error("event counter did not advance");
	trans_quiet_a: assert property (trans_reg |->
		!lg.wr_en ##1 $stable(evt_reg))
		else $error("event counted in transport state");
	trans_sticky_a: assert property (!trans_reg |=> !trans_reg)
		else $error("transport state re-entered");
	finish_cmd_a: assert property (
		i_finish_configuration_command |=> !trans_reg && !setup_reg)
		else $error("finish command did not end transport");
	integ_exit_a: assert property (i_integration |=> !trans_reg)
		else $error("integration left transport state on");
	test_radio_a: assert property (test_reg |-> !radio_reg)
		else $error("radio on inside test menu");
	menu_radio_a: assert property (i_menu_radio_on &&
		!i_integration && !i_finish_configuration_command |=>
		trans_reg == $past(trans_reg))
		else $error("menu radio enable changed transport flag");
	attn_off_a: assert property (word_reg == '0 |=>
		!o_attention_on)
		else $error("attention shown with clear word");
	attn_steady_a: assert property (
		word_reg != '0 && i_info_selected |=> o_attention_on)
		else $error("attention not steady when selected");
	temp_sub_a: assert property (word_reg[BIT_T1_HI] |=>
		o_ser_inlet_temperature == TEMP_MAX_VAL && o_ser_power == '0)
		else $error("open inlet sensor not substituted");
	flow_sub_a: assert property (word_reg[BIT_AIR] |=>
		o_ser_flow == '0 && !o_heat_accum_en)
		else $error("air fault not substituted");
endmodule : info_code_monitor

// File: verif/front_end_model.sv
// Purpose: Sensor front-end model feeding fault levels and eval strobes
// Assumes: Changes its outputs just after the falling clock edge
// Notes:   Fault vector uses status word bit positions; bits 2, 10 unused
`timescale 1ns/10ps
module front_end_model
	import info_mon_pkg::*;
(
	input  wire logic              i_clk_sys,
	output logic                   o_eval,
	output logic [INFO_W-1:0]      o_fault
);
	initial begin
		o_eval = 1'b0;
		o_fault = '0;
	end

	// Levels stay after the strobe, as a real front end holds them
	task automatic measure(input logic [INFO_W-1:0] f);
		@(negedge i_clk_sys);
		o_fault = f;
		o_eval = 1'b1;
		@(negedge i_clk_sys);
		o_eval = 1'b0;
	endtask : measure
endmodule : front_end_model

// File: verif/tb_info_code_monitor.sv
// Purpose: Self-checking bench of the information-code supervisor
// Assumes: Inputs change at the falling edge, reverse hold shortened
// Notes:   Blink phase of the indicator is not checked, too slow
`timescale 1ns/10ps
module tb_info_code_monitor;
	import info_mon_pkg::*;
	logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_eval, i_info_selected;
	logic i_integration, i_finish_configuration_command, i_menu_radio_on;
	logic i_test_menu_enter, i_test_menu_exit;
	logic [INFO_W-1:0] flt, i_bit_enable, o_meter_fault_status_word;
	logic [INFO_W-1:0] o_log_info;
	logic [TEMP_W-1:0] i_inlet_temperature, i_outlet_temperature;
	logic [TEMP_W-1:0] o_ser_inlet_temperature, o_ser_outlet_temperature;
	logic [FLOW_W-1:0] i_flow_volume_channel, o_ser_flow;
	logic [PWR_W-1:0] i_power, o_ser_power;
	logic [DATE_W-1:0] i_date, o_log_date;
	logic [TOD_W-1:0] i_time_of_day, o_log_tod;
	logic [CNT_W-1:0] i_heat_energy_count, i_cooling_energy_count;
	logic [CNT_W-1:0] i_volume_count, o_log_heat, o_log_cool, o_log_vol;
	logic [LOG_IDX_W-1:0] i_log_rd_idx;
	logic [EVT_W-1:0] o_event_count;
	logic o_attention_on, o_transport, o_power_save_seq, o_setup_open;
	logic o_radio_on, o_heat_accum_en, o_cool_accum_en;
	logic o_temp_dashes, o_flow_dashes;
	int err_total = 0, num_checks = 0, n = 0;
	int bl[9] = '{0, 1, 3, 4, 5, 6, 7, 8, 11};
	logic [INFO_W-1:0] f;

	always #20 i_clk_sys = ~i_clk_sys;

	front_end_model front_end_model_inst (.i_clk_sys(i_clk_sys),
		.o_eval(i_eval), .o_fault(flt));

	info_code_monitor #(.REV_HOLD_CYCLES(20)) info_code_monitor_inst (
		.i_supply_lost(flt[0]), .i_low_battery(flt[1]),
		.i_inlet_open(flt[3]), .i_outlet_open(flt[4]),
		.i_inlet_short(flt[5]), .i_outlet_short(flt[6]),
		.i_dt_invalid(flt[7]), .i_flow_air(flt[8]),
		.i_flow_reverse_1pct(flt[9]), .i_flow_over_max_1h(flt[11]),
		.i_technician_menu(1'b0), .*);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset();
		i_sys_rst = 1'b1;
		repeat (10) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_sys_rst = 1'b0;
	endtask : do_reset

	// Word lands one edge after eval, readout one edge later
	task automatic meas(input logic [INFO_W-1:0] v);
		front_end_model_inst.measure(v);
		repeat (2) @(negedge i_clk_sys);
	endtask : meas

	task automatic strobe(input int k);
		@(negedge i_clk_sys);
		case (k)
			0: i_integration = 1'b1;
			1: i_finish_configuration_command = 1'b1;
			2: i_menu_radio_on = 1'b1;
			3: i_test_menu_enter = 1'b1;
			default: i_test_menu_exit = 1'b1;
		endcase
		@(negedge i_clk_sys);
		{i_integration, i_finish_configuration_command} = 2'b00;
		{i_menu_radio_on, i_test_menu_enter, i_test_menu_exit} = 3'b000;
		@(negedge i_clk_sys);
	endtask : strobe

	task automatic rd(input int i);
		i_log_rd_idx = i[5:0];
		repeat (2) @(negedge i_clk_sys);
	endtask : rd

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		err_total++;
		give_verdict();
	end

	initial begin
		i_info_selected = 1'b0;
		i_bit_enable = 12'hfff;
		{i_integration, i_finish_configuration_command} = 2'b00;
		{i_menu_radio_on, i_test_menu_enter, i_test_menu_exit} = 3'b000;
		i_inlet_temperature = 16'h1234;
		i_outlet_temperature = 16'h0abc;
		i_flow_volume_channel = 20'h00321;
		i_power = 20'h00055;
		{i_date, i_time_of_day, i_log_rd_idx} = '0;
		{i_heat_energy_count, i_cooling_energy_count, i_volume_count} = '0;
		do_reset();
		chk(o_transport, 1);
		chk(o_power_save_seq, 1);
		chk(o_radio_on, 0);
		chk(o_attention_on, 0);
		meas(12'h020);
		chk(o_meter_fault_status_word, 32'h20);
		chk(o_event_count, 0);
		chk(o_cool_accum_en, 0);
		i_info_selected = 1'b1;
		repeat (2) @(negedge i_clk_sys);
		chk(o_attention_on, 1);
		i_info_selected = 1'b0;
		strobe(2);
		chk(o_radio_on, 1);
		chk(o_transport, 1);
		strobe(3);
		chk(o_radio_on, 0);
		strobe(0);
		chk(o_transport, 0);
		chk(o_power_save_seq, 0);
		chk(o_radio_on, 0);
		strobe(4);
		strobe(0);
		chk(o_radio_on, 1);
		for (int j = 0; j < 9; j++) begin
			f = 12'h001 << bl[j];
			i_date = 16'(bl[j] + 10);
			i_time_of_day = 17'(bl[j]);
			i_heat_energy_count = 32'(bl[j] * 3);
			i_cooling_energy_count = 32'(bl[j] * 5);
			i_volume_count = 32'(bl[j] * 7);
			meas(f);
			n++;
			chk(o_meter_fault_status_word, f);
			chk(o_event_count, n);
			chk(o_ser_inlet_temperature, f[3] ? TEMP_MAX_VAL :
				f[5] ? TEMP_MIN_VAL : i_inlet_temperature);
			chk(o_ser_outlet_temperature, f[4] ? TEMP_MAX_VAL :
				f[6] ? TEMP_MIN_VAL : i_outlet_temperature);
			chk(o_ser_flow, f[8] ? ZERO_FLOW :
				i_flow_volume_channel);
			chk(o_ser_power, (|f[8:3]) & ~f[7] ? ZERO_POWER :
				i_power);
			chk(o_temp_dashes, |f[6:3]);
			chk(o_flow_dashes, f[8]);
			chk(o_heat_accum_en, !(|f[6:3] || f[8]));
			chk(o_cool_accum_en, !(|f[6:3] || f[8]));
			rd(0);
			chk(o_log_info, f);
			chk(o_log_date, i_date);
			chk(o_log_tod, i_time_of_day);
			chk(o_log_heat, i_heat_energy_count);
			chk(o_log_cool, i_cooling_energy_count);
			chk(o_log_vol, i_volume_count);
		end
		meas(12'h000);
		n++;
		i_bit_enable = 12'hffd;
		meas(12'h002);
		chk(o_meter_fault_status_word, 32'h2);
		chk(o_event_count, n);
		rd(0);
		chk(o_log_info, 0);
		i_bit_enable = 12'hfff;
		meas(12'h000);
		n++;
		repeat (5) front_end_model_inst.measure(12'h200);
		repeat (2) @(negedge i_clk_sys);
		chk(o_meter_fault_status_word, 0);
		repeat (15) front_end_model_inst.measure(12'h200);
		repeat (2) @(negedge i_clk_sys);
		chk(o_meter_fault_status_word, 32'h200);
		chk(o_ser_power, ZERO_POWER);
		meas(12'h000);
		n += 2;
		chk(o_meter_fault_status_word, 0);
		chk(o_event_count, n);
		for (int k = 0; k < 55; k++) begin
			i_date = 16'(100 + k);
			meas(k[0] ? 12'h000 : 12'h001);
		end
		n += 55;
		chk(o_event_count, n);
		rd(0);
		chk(o_log_date, 154);
		rd(49);
		chk(o_log_date, 105);
		do_reset();
		chk(o_setup_open, 1);
		strobe(1);
		chk(o_setup_open, 0);
		chk(o_transport, 0);
		strobe(2);
		meas(12'h001);
		chk(o_transport, 0);
		chk(o_event_count, 1);
		do_reset();
		chk(o_transport, 1);
		give_verdict();
	end
endmodule : tb_info_code_monitor
